// *** core/rtctv_top.sv ***
// Module: APB slave holding the weekday, hours, minutes and seconds digits
// ****************************************
// Operation
// - Pointer 01 selects weekday and hours view
// - Pointer 00 selects minutes and seconds view
// - Weekday digit bits 10-8, 0 to 6
// - Hour tens bits 5-4, 0 to 2
// - Hour ones bits 3-0, 0 to 9
// - Minute tens upper byte, 0 to 5
// - Minute ones upper low nibble, 0 to 9
// - Second tens lower byte, 0 to 5
// - Second ones lowest nibble, 0 to 9
// - Weekday/hours write needs unlock bit set
// ****************************************
`timescale 1ns/10ps
module rtctv_top
   import rtctv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ****************************************
   // State
   // ****************************************
   logic [1:0] ptr_reg, ptr_next;
   logic unlock_reg, unlock_next;
   logic refused_reg, refused_next;
   logic range_reg, range_next;
   logic [2:0] weekday_digit_reg, weekday_digit_next;
   logic [1:0] hour_tens_digit_reg, hour_tens_digit_next;
   logic [3:0] hour_ones_digit_reg, hour_ones_digit_next;
   logic [2:0] minute_tens_digit_reg, minute_tens_digit_next;
   logic [3:0] minute_ones_digit_reg, minute_ones_digit_next;
   logic [2:0] second_tens_digit_reg, second_tens_digit_next;
   logic [3:0] second_ones_digit_reg, second_ones_digit_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pslverr_reg, pslverr_next;
   logic [15:0] window;
   logic setup, access, wr, rd_setup, mapped;
   logic ctrl_hit, win_hit, sts_hit;
   logic ctrl_wr, sts_wr, wkhr_wr, minsec_wr, locked_wr;
   logic wkhr_bad, minsec_bad;
   logic [31:0] rd_word;

   // Digit above its legal BCD ceiling
   function automatic logic over(input logic [3:0] val, input logic [3:0] lim);
      over = (val > lim);
   endfunction

   // Address match against one register offset
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // Any weekday or hour digit beyond its ceiling
   function automatic logic wkhr_range_bad(input logic [31:0] d);
      wkhr_range_bad = over({1'b0, d[RTCTV_WEEKDAY_DIGIT_LSB +: 3]}, RTCTV_WEEKDAY_DIGIT_MAX) ||
                       over({2'b00, d[RTCTV_HOUR_TENS_DIGIT_LSB +: 2]}, RTCTV_HOUR_TENS_DIGIT_MAX) ||
                       over(d[RTCTV_HOUR_ONES_DIGIT_LSB +: 4], RTCTV_ONES_MAX);
   endfunction

   // Any minute or second digit beyond its ceiling
   function automatic logic minsec_range_bad(input logic [31:0] d);
      minsec_range_bad = over({1'b0, d[RTCTV_MINUTE_TENS_DIGIT_LSB +: 3]}, RTCTV_TENS_MAX) ||
                         over(d[RTCTV_MINUTE_ONES_DIGIT_LSB +: 4], RTCTV_ONES_MAX) ||
                         over({1'b0, d[RTCTV_SECOND_TENS_DIGIT_LSB +: 3]}, RTCTV_TENS_MAX) ||
                         over(d[RTCTV_SECOND_ONES_DIGIT_LSB +: 4], RTCTV_ONES_MAX);
   endfunction

   rtctv_window_map u_map (
      .ptr(ptr_reg),
      .weekday_digit(weekday_digit_reg),
      .hour_tens_digit(hour_tens_digit_reg),
      .hour_ones_digit(hour_ones_digit_reg),
      .minute_tens_digit(minute_tens_digit_reg),
      .minute_ones_digit(minute_ones_digit_reg),
      .second_tens_digit(second_tens_digit_reg),
      .second_ones_digit(second_ones_digit_reg),
      .window(window)
   );

   // ****************************************
   // Bus decode
   // ****************************************
   // Read data launches at the setup edge so it already stands at the access edge
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign rd_setup = setup & ~pwrite;
   assign ctrl_hit = hit(paddr, RTCTV_CTRL_OFF);
   assign win_hit = hit(paddr, RTCTV_WINDOW_OFF);
   assign sts_hit = hit(paddr, RTCTV_STATUS_OFF);
   assign mapped = ctrl_hit | win_hit | sts_hit;
   assign ctrl_wr = wr & ctrl_hit;
   assign sts_wr = wr & sts_hit;
   assign wkhr_wr = wr & win_hit & (ptr_reg == RTCTV_PTR_WKHR) & unlock_reg;
   assign minsec_wr = wr & win_hit & (ptr_reg == RTCTV_PTR_MINSEC);
   // Locked write is refused whole, never half applied
   assign locked_wr = wr & win_hit & (ptr_reg == RTCTV_PTR_WKHR) & ~unlock_reg;
   assign wkhr_bad = wkhr_range_bad(pwdata);
   assign minsec_bad = minsec_range_bad(pwdata);
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // ****************************************
   // Window pointer
   // ****************************************
   always_comb begin
      ptr_next = ptr_reg;
      if (ctrl_wr) begin
         ptr_next = pwdata[RTCTV_PTR_LSB +: 2];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ptr_reg <= RTCTV_PTR_RESET;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // ****************************************
   // Write unlock
   // ****************************************
   always_comb begin
      unlock_next = unlock_reg;
      if (ctrl_wr) begin
         unlock_next = pwdata[RTCTV_UNLOCK_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         unlock_reg <= 1'b0;
      end else begin
         unlock_reg <= unlock_next;
      end
   end

   // ****************************************
   // Refused write flag
   // ****************************************
   always_comb begin
      refused_next = refused_reg;
      if (sts_wr && pwdata[RTCTV_STS_REFUSED_BIT]) begin
         refused_next = 1'b0;
      end
      // Set comes after clear so the hardware event wins
      if (locked_wr) begin
         refused_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         refused_reg <= 1'b0;
      end else begin
         refused_reg <= refused_next;
      end
   end

   // ****************************************
   // Digit range flag
   // ****************************************
   always_comb begin
      range_next = range_reg;
      if (sts_wr && pwdata[RTCTV_STS_RANGE_BIT]) begin
         range_next = 1'b0;
      end
      // Bad digits are still stored; this flag is the only trace
      if ((wkhr_wr && wkhr_bad) || (minsec_wr && minsec_bad)) begin
         range_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         range_reg <= 1'b0;
      end else begin
         range_reg <= range_next;
      end
   end

   // ****************************************
   // Weekday and hours digits
   // ****************************************
   always_comb begin
      weekday_digit_next = weekday_digit_reg;
      hour_tens_digit_next = hour_tens_digit_reg;
      hour_ones_digit_next = hour_ones_digit_reg;
      if (wkhr_wr) begin
         weekday_digit_next = pwdata[RTCTV_WEEKDAY_DIGIT_LSB +: 3];
         hour_tens_digit_next = pwdata[RTCTV_HOUR_TENS_DIGIT_LSB +: 2];
         hour_ones_digit_next = pwdata[RTCTV_HOUR_ONES_DIGIT_LSB +: 4];
      end
   end

   // No reset: the digits mean nothing until software loads them
   always_ff @(posedge sys_clk) begin
      weekday_digit_reg <= weekday_digit_next;
      hour_tens_digit_reg <= hour_tens_digit_next;
      hour_ones_digit_reg <= hour_ones_digit_next;
   end

   // ****************************************
   // Minutes and seconds digits
   // ****************************************
   always_comb begin
      minute_tens_digit_next = minute_tens_digit_reg;
      minute_ones_digit_next = minute_ones_digit_reg;
      second_tens_digit_next = second_tens_digit_reg;
      second_ones_digit_next = second_ones_digit_reg;
      if (minsec_wr) begin
         minute_tens_digit_next = pwdata[RTCTV_MINUTE_TENS_DIGIT_LSB +: 3];
         minute_ones_digit_next = pwdata[RTCTV_MINUTE_ONES_DIGIT_LSB +: 4];
         second_tens_digit_next = pwdata[RTCTV_SECOND_TENS_DIGIT_LSB +: 3];
         second_ones_digit_next = pwdata[RTCTV_SECOND_ONES_DIGIT_LSB +: 4];
      end
   end

   always_ff @(posedge sys_clk) begin
      minute_tens_digit_reg <= minute_tens_digit_next;
      minute_ones_digit_reg <= minute_ones_digit_next;
      second_tens_digit_reg <= second_tens_digit_next;
      second_ones_digit_reg <= second_ones_digit_next;
   end

   // ****************************************
   // Read multiplexer
   // ****************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         RTCTV_CTRL_OFF: begin
            rd_word[RTCTV_PTR_LSB +: 2] = ptr_reg;
            rd_word[RTCTV_UNLOCK_BIT] = unlock_reg;
         end
         RTCTV_WINDOW_OFF: begin
            rd_word = {16'h0000, window};
         end
         RTCTV_STATUS_OFF: begin
            rd_word[RTCTV_STS_REFUSED_BIT] = refused_reg;
            rd_word[RTCTV_STS_RANGE_BIT] = range_reg;
         end
         default: begin
            // Unmapped offsets read as zero
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      prdata_next = prdata_reg;
      // Holds between reads so a late sample still sees the last word
      if (rd_setup) begin
         prdata_next = rd_word;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   // ****************************************
   // Error response
   // ****************************************
   always_comb begin
      pslverr_next = 1'b0;
      // Raised at setup so it stands for exactly the access phase
      if (setup && !mapped) begin
         pslverr_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= pslverr_next;
      end
   end
endmodule // rtctv_top

// *** core/rtctv_pkg.sv ***
// Package: register map, field layout and encodings for the time value registers
package rtctv_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] RTCTV_CTRL_OFF = 8'h00;
   localparam logic [7:0] RTCTV_WINDOW_OFF = 8'h04;
   localparam logic [7:0] RTCTV_STATUS_OFF = 8'h08;
   // ****************************************
   // Control register fields
   // ****************************************
   localparam int RTCTV_PTR_LSB = 0;
   localparam int RTCTV_UNLOCK_BIT = 8;
   localparam logic [1:0] RTCTV_PTR_MINSEC = 2'h0;
   localparam logic [1:0] RTCTV_PTR_WKHR = 2'h1;
   localparam logic [1:0] RTCTV_PTR_RESET = 2'h0;
   // ****************************************
   // Window field positions
   // ****************************************
   localparam int RTCTV_WEEKDAY_DIGIT_LSB = 8;
   localparam int RTCTV_HOUR_TENS_DIGIT_LSB = 4;
   localparam int RTCTV_HOUR_ONES_DIGIT_LSB = 0;
   localparam int RTCTV_MINUTE_TENS_DIGIT_LSB = 12;
   localparam int RTCTV_MINUTE_ONES_DIGIT_LSB = 8;
   localparam int RTCTV_SECOND_TENS_DIGIT_LSB = 4;
   localparam int RTCTV_SECOND_ONES_DIGIT_LSB = 0;
   // ****************************************
   // Legal digit limits
   // ****************************************
   localparam logic [3:0] RTCTV_WEEKDAY_DIGIT_MAX = 4'h6;
   localparam logic [3:0] RTCTV_HOUR_TENS_DIGIT_MAX = 4'h2;
   localparam logic [3:0] RTCTV_TENS_MAX = 4'h5;
   localparam logic [3:0] RTCTV_ONES_MAX = 4'h9;
   // ****************************************
   // Status register fields
   // ****************************************
   localparam int RTCTV_STS_REFUSED_BIT = 0;
   localparam int RTCTV_STS_RANGE_BIT = 1;
endpackage

// *** core/rtctv_window_map.sv ***
// Module: maps the stored digits onto the shared 16-bit value window
`timescale 1ns/10ps
module rtctv_window_map
   import rtctv_pkg::*;
(
   input wire logic [1:0] ptr,
   input wire logic [2:0] weekday_digit,
   input wire logic [1:0] hour_tens_digit,
   input wire logic [3:0] hour_ones_digit,
   input wire logic [2:0] minute_tens_digit,
   input wire logic [3:0] minute_ones_digit,
   input wire logic [2:0] second_tens_digit,
   input wire logic [3:0] second_ones_digit,
   output logic [15:0] window
);
   // ****************************************
   // View select
   // ****************************************
   always_comb begin
      window = 16'h0000;
      if (ptr == RTCTV_PTR_WKHR) begin
         window[RTCTV_WEEKDAY_DIGIT_LSB +: 3] = weekday_digit;
         window[RTCTV_HOUR_TENS_DIGIT_LSB +: 2] = hour_tens_digit;
         window[RTCTV_HOUR_ONES_DIGIT_LSB +: 4] = hour_ones_digit;
      end else if (ptr == RTCTV_PTR_MINSEC) begin
         window[RTCTV_MINUTE_TENS_DIGIT_LSB +: 3] = minute_tens_digit;
         window[RTCTV_MINUTE_ONES_DIGIT_LSB +: 4] = minute_ones_digit;
         window[RTCTV_SECOND_TENS_DIGIT_LSB +: 3] = second_tens_digit;
         window[RTCTV_SECOND_ONES_DIGIT_LSB +: 4] = second_ones_digit;
      end
   end
endmodule // rtctv_window_map

// *** tb/rtctv_props.sv ***
// Checker: APB answer timing and window bit layout
`timescale 1ns/10ps
module rtctv_props
   import rtctv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic acc;
   logic rd_win;
   logic mapped;
   logic [1:0] ptr_reg;
   logic [1:0] ptr_next;
   assign acc = psel & penable;
   assign rd_win = acc && !pwrite && paddr == RTCTV_WINDOW_OFF;
   assign mapped = paddr inside {RTCTV_CTRL_OFF, RTCTV_WINDOW_OFF, RTCTV_STATUS_OFF};
   always_comb begin
      ptr_next = ptr_reg;
      if (acc && pwrite && paddr == RTCTV_CTRL_OFF) begin
         ptr_next = pwdata[RTCTV_PTR_LSB +: 2];
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ptr_reg <= RTCTV_PTR_RESET;
      end else begin
         ptr_reg <= ptr_next;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_upper_half_zero: assert property (rd_win |-> prdata[31:16] == 16'h0000)
      else $error("window upper half set");
   a_wkhr_gaps_zero: assert property (rd_win && ptr_reg == RTCTV_PTR_WKHR |->
      prdata[15:11] == 5'h00 && prdata[7:6] == 2'h0) else $error("weekday gaps set");
   a_minsec_gaps_zero: assert property (rd_win && ptr_reg == RTCTV_PTR_MINSEC |->
      !prdata[15] && !prdata[7]) else $error("minsec gaps set");
   a_ptr_reads_back: assert property (acc && !pwrite && paddr == RTCTV_CTRL_OFF |->
      prdata[1:0] == ptr_reg) else $error("pointer readback wrong");
   a_ctrl_gaps_zero: assert property (acc && !pwrite && paddr == RTCTV_CTRL_OFF |->
      prdata[31:9] == 23'h0 && prdata[7:2] == 6'h00) else $error("control gaps set");
   a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error");
   a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("false error");
   a_err_idle: assert property (!acc |-> !pslverr) else $error("error while idle");
   a_data_holds: assert property (psel && !penable && pwrite |=> $stable(prdata))
      else $error("prdata moved");
   c_wkhr_read: cover property (rd_win && ptr_reg == RTCTV_PTR_WKHR);
   c_minsec_read: cover property (rd_win && ptr_reg == RTCTV_PTR_MINSEC);
   c_unmapped: cover property (acc && !mapped);
endmodule // rtctv_props
bind rtctv_top rtctv_props u_rtctv_props (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// *** tb/rtctv_top_test.sv ***
// Testbench: APB scenarios for the time value registers
`timescale 1ns/10ps
module rtctv_top_test;
   import rtctv_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   rtctv_top u_rtctv_top (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Request stands until pready is seen high; data and error are taken at that edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic t_views;
      xfer(1, RTCTV_WINDOW_OFF, 32'hffff_d9d9);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("minsec", 32'h0000_5959, rd);
      xfer(1, RTCTV_CTRL_OFF, 32'h0000_0101);
      xfer(1, RTCTV_WINDOW_OFF, 32'hffff_f6e9);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("wkhr", 32'h0000_0629, rd);
      xfer(1, RTCTV_CTRL_OFF, 32'h0);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("minsec kept", 32'h0000_5959, rd);
      $display("test views done");
   endtask
   task automatic t_locked;
      xfer(1, RTCTV_CTRL_OFF, 32'hffff_fefd);
      xfer(0, RTCTV_CTRL_OFF, 32'h0);
      chk("ctrl", 32'h0000_0001, rd);
      xfer(1, RTCTV_WINDOW_OFF, 32'h0);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("locked wkhr", 32'h0000_0629, rd);
      xfer(0, RTCTV_STATUS_OFF, 32'h0);
      chk("refused flag", 32'h0000_0001, rd);
      xfer(1, RTCTV_STATUS_OFF, 32'h0000_0001);
      xfer(0, RTCTV_STATUS_OFF, 32'h0);
      chk("flag cleared", 32'h0, rd);
      xfer(1, RTCTV_CTRL_OFF, 32'h0000_0101);
      xfer(1, RTCTV_WINDOW_OFF, 32'h0);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("unlocked wkhr", 32'h0, rd);
      $display("test locked done");
   endtask
   task automatic t_range;
      xfer(1, RTCTV_CTRL_OFF, 32'h0);
      xfer(1, RTCTV_WINDOW_OFF, 32'h0000_7a7a);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("minsec raw", 32'h0000_7a7a, rd);
      xfer(0, RTCTV_STATUS_OFF, 32'h0);
      chk("range flag", 32'h0000_0002, rd);
      xfer(1, RTCTV_STATUS_OFF, 32'h0000_0002);
      xfer(0, RTCTV_STATUS_OFF, 32'h0);
      chk("range cleared", 32'h0, rd);
      xfer(1, RTCTV_CTRL_OFF, 32'h0000_0002);
      xfer(1, RTCTV_WINDOW_OFF, 32'h0000_1234);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("ptr 10 window", 32'h0, rd);
      xfer(1, RTCTV_CTRL_OFF, 32'h0);
      xfer(0, RTCTV_WINDOW_OFF, 32'h0);
      chk("minsec unchanged", 32'h0000_7a7a, rd);
      $display("test range done");
   endtask
   task automatic t_errors;
      xfer(0, 8'h0c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      xfer(1, 8'h0c, 32'hffff_ffff);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      xfer(0, RTCTV_CTRL_OFF, 32'h0);
      chk("mapped err", 32'h0, {31'h0, err});
      $display("test errors done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Whole run is about 112 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         conclude;
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      xfer(0, RTCTV_CTRL_OFF, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      t_views;
      t_locked;
      t_range;
      t_errors;
      conclude;
   end
endmodule // rtctv_top_test
